/* File: phy_port_consts.vh */
// Purpose: Constants for the MAC-side port, strap latch and pin mux.
// Assumes: APB byte addresses; 32-bit data; pclk at 100 MHz.
// Notes:   Definitions only; included by bare name.
`ifndef PHY_PORT_CONSTS_VH
`define PHY_PORT_CONSTS_VH

// Register byte addresses
`define REG_CTRL_ADDR      12'h000
`define REG_STATUS_ADDR    12'h004

// Control register fields and reset value
`define CTRL_IRQ_POL_BIT   0
`define CTRL_LED_A_LSB     4
`define CTRL_LED_B_LSB     8
`define CTRL_RESET         32'h0000_0100

// LED function codes
`define LED_SEL_ACTIVITY   2'h0
`define LED_SEL_SPEED      2'h1
`define LED_SEL_LINK       2'h2
`define LED_SEL_COLLISION  2'h3

// Status register fields
`define STAT_ADDR_LSB      0
`define STAT_CROSSOVER_BIT 4
`define STAT_RX_TRISTATE_BIT 5
`define STAT_DUPLEX_BIT    6
`define STAT_RMII_BIT      7
`define STAT_AUTONEG_BIT   8
`define STAT_NODE_BIT      9
`define STAT_SPEED_BIT     10
`define STAT_VALID_BIT     11
`define STAT_ISOLATE_BIT   12

// Shared pin indices
`define PIN_ADDR0_LED_A    0
`define PIN_ADDR1_LED_B    1
`define PIN_ADDR2_IRQ      2
`define PIN_ADDR3_RXD2     3
`define PIN_RXD3           4
`define PIN_RXD1           5
`define PIN_RXD0           6
`define PIN_RXDV           7
`define PIN_RXCLK          8
`define PIN_RXER           9
`define PIN_TXCLK          10
`define PIN_COUNT          11

// Interface select strap encoding
`define SEL_RMII           1'b1

// Edges to wait after reset release before straps are taken
`define CAPTURE_WAIT       2'h3

// Nominal reference clock rates in MHz
`define REF_MII_MHZ        25
`define REF_RMII_MHZ       50

`endif

/* File: sync_bits.v */
// Purpose: Two flip-flop synchroniser for a vector of levels.
// Assumes: Each bit is an independent level from another domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
module sync_bits
#(
    parameter WIDTH = 1
)
(
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;

    // Two stages; constants only under reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* File: mac_port_straps.v */
// Purpose: MAC-facing MII/RMII port with reset strap latch and pin mux.
// Assumes: Reference clock and MAC pins are foreign; core side is on pclk.
// Notes:   Reference clock is oversampled; its edges pace the data path.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "phy_port_consts.vh"

// Functional notes
// R1: MII receive nibble follows receive clock, meaningful only while valid.
// R2: RMII sends two receive bits per reference period while CRS_DV high.
// R3: MII transmit nibble sampled on transmit clock only while enable high.
// R4: Reference is 25 MHz in MII and 50 MHz in RMII.
// R5: Crystal drive output floats in RMII, drives crystal in MII.
// R6: Valid pin carries receive valid in MII, CRS_DV in RMII.
// R7: Receive bits 0,1 driven in both modes; bits 2,3 only in MII.
// R8: Transmit bits 0,1 used in both modes; bits 2,3 only in MII.
// R9: Receive and transmit clock pins driven only in MII.
// R10: Hardware reset clears all strap and interface logic.
// R11: Address bits 0..3 latched from shared pins, which then become outputs; code leaves pin 1 off with rx_tristate_strap, pin 3 off in RMII.
// R12: Mode straps sampled at reset, pins then revert to outputs; code keeps RXD3 and both clock pins off in RMII.
// R13: Interrupt pin active low by default, polarity programmable.
// R14: LED A defaults to activity, function selectable.
// R15: LED B defaults to speed, function selectable.
// R16: After latch, LED B pin may act as receiver isolation input.
// R17: Board holds node-select pin low during reset.
// R18: RMII transmit takes two bits per reference period while enable high.
// R19: Interface strap 1 selects RMII, 0 selects MII.
// R20: Receive tristate strap high turns LED B pin into isolation input.
// R21: Straps captured after reset release; drivers enabled only after that.
// R22: Strap pin drivers stay off while straps are sampled.
module mac_port_straps
(
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Reference clock and crystal drive
    input  wire        ref_clock_in,
    output reg         crystal_drive_out,
    output reg         crystal_drive_oe,
    // MAC transmit pins
    input  wire        tx_en_pin,
    input  wire [3:0]  tx_data_pin,
    // Shared strap/output pins
    input  wire [10:0] strap_pin_in,
    output reg  [10:0] strap_pin_out,
    output reg  [10:0] strap_pin_oe,
    // Core receive side
    input  wire [3:0]  rx_data_in,
    input  wire        rx_valid_in,
    input  wire        rx_error_in,
    // Core transmit side
    output reg  [3:0]  tx_nibble_out,
    output reg         tx_valid_out,
    // Core events for LEDs and interrupt
    input  wire        irq_event_in,
    input  wire        activity_in,
    input  wire        speed100_in,
    input  wire        link_in,
    input  wire        collision_in,
    // Latched configuration and live isolation input
    output reg  [3:0]  phy_addr,
    output reg         crossover_auto_strap,
    output reg         rx_tristate_strap,
    output reg         full_duplex_strap,
    output reg         rmii_mode,
    output reg         autoneg_enable_strap,
    output reg         node_select_strap,
    output reg         speed_100_strap,
    output reg         straps_valid,
    output wire        rx_isolate
);

    wire [16:0] raw_async;
    wire [16:0] synced;
    wire [10:0] pin_s;
    wire        ref_s;
    wire        tx_en_s;
    wire [3:0]  tx_data_s;
    reg         ref_d_reg;
    reg  [1:0]  wait_reg;
    reg  [31:0] ctrl_reg;
    wire        ref_rise;
    wire        ref_fall;
    wire        mii;
    wire        drive_rx;
    wire        irq_pol;
    wire [1:0]  led_a_sel;
    wire [1:0]  led_b_sel;
    wire [31:0] status_word;
    wire        addr_ok;

    // Every foreign input passes two flops before use
    assign raw_async = {tx_data_pin, tx_en_pin, ref_clock_in, strap_pin_in};

    sync_bits
    #(
        .WIDTH (17)
    )
    u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_async),
        .sync_out (synced)
    );

    assign pin_s     = synced[10:0];
    assign ref_s     = synced[11];
    assign tx_en_s   = synced[12];
    assign tx_data_s = synced[16:13];

    // Reference edge finder on the synchronised level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ref_d_reg <= 1'b0;
        else
            ref_d_reg <= ref_s;
    end

    assign ref_rise = ref_s & ~ref_d_reg;
    assign ref_fall = ~ref_s & ref_d_reg;

    // Strap capture: wait for the synchroniser to fill after release,
    // so the pulls, not stale reset zeros, set the latched level.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)                                          // [R10]
        begin
            wait_reg             <= 2'h0;
            straps_valid         <= 1'b0;
            phy_addr             <= 4'h0;
            crossover_auto_strap <= 1'b0;
            rx_tristate_strap    <= 1'b0;
            full_duplex_strap    <= 1'b0;
            rmii_mode            <= 1'b0;
            autoneg_enable_strap <= 1'b0;
            node_select_strap    <= 1'b0;
            speed_100_strap      <= 1'b0;
        end
        else if (!straps_valid)
        begin
            if (wait_reg == `CAPTURE_WAIT)                     // [R21]
            begin
                straps_valid         <= 1'b1;
                phy_addr[0]          <= pin_s[`PIN_ADDR0_LED_A]; // [R11]
                phy_addr[1]          <= pin_s[`PIN_ADDR1_LED_B];
                phy_addr[2]          <= pin_s[`PIN_ADDR2_IRQ];
                phy_addr[3]          <= pin_s[`PIN_ADDR3_RXD2];
                crossover_auto_strap <= pin_s[`PIN_RXD3];        // [R12]
                rx_tristate_strap    <= pin_s[`PIN_RXD1];
                full_duplex_strap    <= pin_s[`PIN_RXD0];
                rmii_mode <= (pin_s[`PIN_RXDV] == `SEL_RMII);  // [R19]
                autoneg_enable_strap <= pin_s[`PIN_RXCLK];
                node_select_strap    <= pin_s[`PIN_RXER];      // [R17]
                speed_100_strap      <= pin_s[`PIN_TXCLK];
            end
            else
                wait_reg <= wait_reg + 2'h1;
        end
    end

    // Mode and isolation decode
    assign mii        = ~rmii_mode;
    assign rx_isolate = rx_tristate_strap & straps_valid
                        & pin_s[`PIN_ADDR1_LED_B];             // [R16]
    assign drive_rx   = straps_valid & ~rx_isolate;
    assign irq_pol    = ctrl_reg[`CTRL_IRQ_POL_BIT];
    assign led_a_sel  = ctrl_reg[`CTRL_LED_A_LSB+1:`CTRL_LED_A_LSB];
    assign led_b_sel  = ctrl_reg[`CTRL_LED_B_LSB+1:`CTRL_LED_B_LSB];

    // LED function mux shared by both LEDs
    function led_pick;
        input [1:0] sel;
        input       act;
        input       spd;
        input       lnk;
        input       col;
        begin
            case (sel)
                `LED_SEL_ACTIVITY: led_pick = act;
                `LED_SEL_SPEED:    led_pick = spd;
                `LED_SEL_LINK:     led_pick = lnk;
                `LED_SEL_COLLISION: led_pick = col;
                default:           led_pick = act;
            endcase
        end
    endfunction

    // Output enables; all off until capture so pulls set strap levels
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_pin_oe <= 11'h000;                           // [R22]
        else
        begin
            strap_pin_oe[`PIN_ADDR0_LED_A] <= straps_valid;
            strap_pin_oe[`PIN_ADDR1_LED_B] <= straps_valid
                                              & ~rx_tristate_strap; // [R20]
            strap_pin_oe[`PIN_ADDR2_IRQ]   <= straps_valid;
            strap_pin_oe[`PIN_ADDR3_RXD2]  <= drive_rx & mii;  // [R7]
            strap_pin_oe[`PIN_RXD3]        <= drive_rx & mii;
            strap_pin_oe[`PIN_RXD1]        <= drive_rx;
            strap_pin_oe[`PIN_RXD0]        <= drive_rx;
            strap_pin_oe[`PIN_RXDV]        <= drive_rx;
            strap_pin_oe[`PIN_RXCLK]       <= straps_valid & mii; // [R9]
            strap_pin_oe[`PIN_RXER]        <= drive_rx;
            strap_pin_oe[`PIN_TXCLK]       <= straps_valid & mii;
        end
    end

    // Pin data: clocks follow the reference, receive data changes on
    // its falling edge so the MAC sees it stable at the rising edge.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_pin_out <= 11'h000;
        else
        begin
            strap_pin_out[`PIN_ADDR0_LED_A] <= led_pick(led_a_sel,
                activity_in, speed100_in, link_in, collision_in); // [R14]
            strap_pin_out[`PIN_ADDR1_LED_B] <= led_pick(led_b_sel,
                activity_in, speed100_in, link_in, collision_in); // [R15]
            strap_pin_out[`PIN_ADDR2_IRQ]   <= irq_pol ? irq_event_in // [R13]
                                                       : ~irq_event_in;
            strap_pin_out[`PIN_RXCLK]       <= ref_s & mii;
            strap_pin_out[`PIN_TXCLK]       <= ref_s & mii;
            if (ref_fall)
            begin
                // Data is zeroed outside valid; MAC must ignore it anyway
                strap_pin_out[`PIN_RXD0] <= rx_valid_in
                                            & rx_data_in[0]; // [R1]
                strap_pin_out[`PIN_RXD1] <= rx_valid_in
                                            & rx_data_in[1]; // [R2]
                strap_pin_out[`PIN_ADDR3_RXD2] <= rx_valid_in & mii
                                                  & rx_data_in[2];
                strap_pin_out[`PIN_RXD3] <= rx_valid_in & mii
                                            & rx_data_in[3];
                strap_pin_out[`PIN_RXDV] <= rx_valid_in;       // [R6]
                strap_pin_out[`PIN_RXER] <= rx_error_in;
            end
        end
    end

    // Crystal drive: inverted reference in MII, floating in RMII
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crystal_drive_out <= 1'b0;
            crystal_drive_oe  <= 1'b0;
        end
        else
        begin
            crystal_drive_out <= ~ref_s & mii;
            crystal_drive_oe  <= straps_valid & mii;           // [R5]
        end
    end

    // Transmit capture on reference rise: the same sampled clock paces
    // MII at 25 MHz and RMII at 50 MHz, so no mode-specific timer.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_nibble_out <= 4'h0;
            tx_valid_out  <= 1'b0;
        end
        else
        begin
            tx_valid_out <= 1'b0;
            if (ref_rise && straps_valid && tx_en_s)           // [R3] [R4]
            begin
                tx_valid_out       <= 1'b1;
                tx_nibble_out[1:0] <= tx_data_s[1:0];          // [R18]
                tx_nibble_out[3:2] <= mii ? tx_data_s[3:2]
                                          : 2'h0;              // [R8]
            end
        end
    end

    // APB slave: zero wait states, error on unmapped address
    assign addr_ok = (paddr == `REG_CTRL_ADDR)
                     || (paddr == `REG_STATUS_ADDR);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    assign status_word = {19'h0_0000,
                          rx_isolate, straps_valid, speed_100_strap,
                          node_select_strap, autoneg_enable_strap,
                          rmii_mode, full_duplex_strap, rx_tristate_strap,
                          crossover_auto_strap, phy_addr};

    // Control writes take effect at the access edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `CTRL_RESET;
        else if (psel && penable && pwrite
                 && paddr == `REG_CTRL_ADDR)
            ctrl_reg <= pwdata & 32'h0000_0331;
    end

    // Read data registered in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `REG_CTRL_ADDR:   prdata <= ctrl_reg;
                `REG_STATUS_ADDR: prdata <= status_word;
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: mac_tx_model.sv */
// Purpose: MAC-side transmit model driving the port's transmit pins.
// Assumes: Data changes on the falling reference edge, sampled on the rise.
// Notes:   Sends three values; an optional idle gap tests enable gating.
`timescale 1ns/1ns
module mac_tx_model
(
    // Reference clock and control from the bench
    input  wire       ref_clk,
    input  wire       go,
    input  wire       gap,
    input  wire [3:0] first,
    // MAC transmit pins
    output reg        tx_en,
    output reg  [3:0] tx_data
);
    integer k;
    // Idle with enable low before the first frame
    initial
    begin
        tx_en = 1'b0;
        tx_data = 4'h0;
    end
    // One value per reference period, stable across the rising edge
    always @(posedge go)
    begin
        for (k = 0; k < 3; k = k + 1)
        begin
            @(negedge ref_clk);
            if (gap && k == 2)
            begin
                tx_en <= 1'b0;
                tx_data <= 4'hF;
                @(negedge ref_clk);
            end
            tx_en <= 1'b1;
            tx_data <= first + k[3:0];
        end
        // Released pins show the inverse so stale data cannot pass
        @(negedge ref_clk);
        tx_en <= 1'b0;
        tx_data <= ~tx_data;
    end
endmodule

/* File: mac_port_straps_checker.sv */
// Purpose: Checker for the port, strap latch and pin mux outputs.
// Assumes: Strap pins stay steady around the capture after reset.
// Notes:   One domain on pclk; bound to the block below.
`timescale 1ns/1ns
module mac_port_straps_checker
(
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // Watched ports
    input wire [10:0] strap_pin_in,
    input wire [10:0] strap_pin_oe,
    input wire        crystal_drive_oe,
    input wire [3:0]  tx_nibble_out,
    input wire        tx_valid_out,
    input wire [3:0]  phy_addr,
    input wire        rmii_mode,
    input wire        rx_tristate_strap,
    input wire        straps_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst; disable iff (1'b0)
        !presetn |-> strap_pin_oe == 11'h000 && !straps_valid; endproperty
    a_rst: assert property (p_rst) else $error("pins driven in reset");
    property p_early; !straps_valid |-> strap_pin_oe == 11'h000; endproperty
    a_early: assert property (p_early)
        else $error("driver before capture");
    property p_xtal; crystal_drive_oe |-> !rmii_mode; endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal drive in rmii");
    property p_upper; |strap_pin_oe[4:3] |-> !rmii_mode; endproperty
    a_upper: assert property (p_upper)
        else $error("upper rx bits in rmii");
    property p_clks; strap_pin_oe[8] || strap_pin_oe[10] |-> !rmii_mode;
    endproperty
    a_clks: assert property (p_clks) else $error("clock pins in rmii");
    property p_addr;
        $rose(straps_valid) |-> phy_addr == $past(strap_pin_in[3:0], 2);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address not latched");
    property p_mode;
        $rose(straps_valid) |-> rmii_mode == $past(strap_pin_in[7], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not latched");
    property p_iso; rx_tristate_strap |-> !strap_pin_oe[1]; endproperty
    a_iso: assert property (p_iso) else $error("led b driven");
    property p_dibit; tx_valid_out && rmii_mode |-> tx_nibble_out[3:2] == 2'h0;
    endproperty
    a_dibit: assert property (p_dibit)
        else $error("upper tx bits used");
    property p_once; tx_valid_out |=> !tx_valid_out [*4]; endproperty
    a_once: assert property (p_once) else $error("tx valid too long");
endmodule
bind mac_port_straps mac_port_straps_checker i_chk (.pclk, .presetn,
    .strap_pin_in, .strap_pin_oe, .crystal_drive_oe, .tx_nibble_out,
    .tx_valid_out, .phy_addr, .rmii_mode, .rx_tristate_strap, .straps_valid);

/* File: mac_port_straps_tb.sv */
// Purpose: Self-checking bench for the MAC port with strap latch.
// Assumes: Undriven strap pins take the level of the bench pulls.
// Notes:   Reference runs free at 80 ns, out of phase with pclk.
`timescale 1ns/1ns
`include "phy_port_consts.vh"
module mac_port_straps_tb;
    reg         pclk, presetn, psel, penable, pwrite, ref_clk, go, gap;
    reg         rxv, rxe, irq, e;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, q;
    reg  [10:0] pull;
    reg  [3:0]  rxd, ev, first;
    reg  [1:0]  led, s;
    wire        pready, pslverr, xoe, xout, tx_en, txv, iso;
    wire [31:0] prdata;
    wire [3:0]  tx_d, txn;
    wire [10:0] pin_out, pin_oe, pin_in;
    integer     err_count, checks, n;
    // Pin level: the block where it drives, the pull elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
    mac_port_straps i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .ref_clock_in(ref_clk),
        .crystal_drive_out(xout), .crystal_drive_oe(xoe), .tx_en_pin(tx_en),
        .tx_data_pin(tx_d), .strap_pin_in(pin_in), .strap_pin_out(pin_out),
        .strap_pin_oe(pin_oe), .rx_data_in(rxd), .rx_valid_in(rxv),
        .rx_error_in(rxe), .tx_nibble_out(txn), .tx_valid_out(txv),
        .irq_event_in(irq), .activity_in(ev[0]), .speed100_in(ev[1]),
        .link_in(ev[2]), .collision_in(ev[3]), .phy_addr(),
        .crossover_auto_strap(), .rx_tristate_strap(), .full_duplex_strap(),
        .rmii_mode(), .autoneg_enable_strap(), .node_select_strap(),
        .speed_100_strap(), .straps_valid(), .rx_isolate(iso)
    );
    mac_tx_model i_mac
    (
        .ref_clk(ref_clk), .go(go), .gap(gap), .first(first),
        .tx_en(tx_en), .tx_data(tx_d)
    );
    // Clocks; the reference is offset so its edges never meet pclk edges
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        ref_clk = 1'b0;
        #3;
        forever #40 ref_clk = ~ref_clk;
    end
    // Compare and count
    task chk(input string nm, input [31:0] x, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== x)
            begin
                err_count = err_count + 1;
                $display("wrong value %0s exp %h got %h", nm, x, g);
            end
        end
    endtask
    // One APB transfer, held until pready is seen high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task test_done;
        begin
            $display("checks %0d err_count %0d", checks, err_count);
            if (err_count == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Reset with given strap pulls, then read back the latched status
    task rst(input [10:0] p);
        begin
            pull <= p;
            presetn <= 1'b0;
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            repeat (8) @(posedge pclk);
            apb(1'b0, `REG_STATUS_ADDR, 32'h0000_0000);
            chk("status", {19'h0, p[1] & p[5], 1'b1, p}, q);
            $display("reset test done");
        end
    endtask
    // Selected event must steer both LED pins
    task led_t(input [1:0] sa, input [1:0] sb);
        begin
            ev <= (4'h1 << sa) | (4'h1 << sb);
            repeat (4) @(posedge pclk);
            led = pin_out[1:0];
            ev <= ~((4'h1 << sa) | (4'h1 << sb));
            repeat (4) @(posedge pclk);
            chk("led", 4'hF, {pin_oe[1:0], led ^ pin_out[1:0]});
        end
    endtask
    task t_regs;
        begin
            apb(1'b0, `REG_CTRL_ADDR, 32'h0000_0000);
            chk("ctrl reset", 32'h0000_0100, q);
            apb(1'b1, `REG_CTRL_ADDR, 32'hFFFF_FFFF);
            apb(1'b0, `REG_CTRL_ADDR, 32'h0000_0000);
            chk("ctrl mask", 32'h0000_0331, q);
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk("unmapped", 32'h0000_0001, {q[30:0], e});
            apb(1'b1, `REG_CTRL_ADDR, 32'h0000_0100);
            $display("register test done");
        end
    endtask
    // Interrupt pin low by default, high after polarity change
    task t_irq;
        begin
            irq <= 1'b1;
            repeat (4) @(posedge pclk);
            chk("irq low", 2'h2, {pin_oe[2], pin_out[2]});
            apb(1'b1, `REG_CTRL_ADDR, 32'h0000_0101);
            repeat (4) @(posedge pclk);
            chk("irq high", 2'h3, {pin_oe[2], pin_out[2]});
            irq <= 1'b0;
            repeat (4) @(posedge pclk);
            chk("irq idle", 2'h2, {pin_oe[2], pin_out[2]});
            for (n = 0; n < 4; n = n + 1)
            begin
                s = n[1:0];
                apb(1'b1, `REG_CTRL_ADDR, {22'h0, s + 2'h1, 2'h0, s, 4'h0});
                led_t(s, s + 2'h1);
            end
            $display("irq and led test done");
        end
    endtask
    // Three values from the MAC, each seen once, masked to the mode
    task tx_t(input [3:0] f, input g, input [3:0] m);
        begin
            first <= f;
            gap <= g;
            go <= 1'b1;
            for (n = 0; n < 3; n = n + 1)
            begin
                do @(posedge pclk); while (txv !== 1'b1);
                chk("tx", (f + n[3:0]) & m, txn);
            end
            go <= 1'b0;
            n = 0;
            repeat (40) @(posedge pclk) if (txv === 1'b1) n = n + 1;
            chk("tx idle", 0, n);
            $display("transmit test done");
        end
    endtask
    // Receive path: data while valid, zero otherwise, pins per mode;
    // crystal and clock pins must toggle only when the crystal drives
    task rx_t(input [31:0] x, input [31:0] oe);
        begin
            rxv <= 1'b1;
            rxe <= 1'b1;
            rxd <= 4'hA;
            pull[1] <= 1'b0;
            repeat (3) @(posedge ref_clk);
            @(posedge pclk);
            q = {pin_out[9], pin_out[7], pin_out[4:3], pin_out[5], pin_out[6]};
            chk("rx", x, q);
            chk("rx oe", oe, {xoe, pin_oe[10], pin_oe[8:3]});
            e = xout;
            led = {pin_out[10], pin_out[8]};
            repeat (4) @(posedge pclk);
            q = {e ^ xout, led ^ {pin_out[10], pin_out[8]}};
            chk("clocks", {3{oe[7]}}, q);
            rxv <= 1'b0;
            rxe <= 1'b0;
            repeat (3) @(posedge ref_clk);
            @(posedge pclk);
            chk("rx idle", 0, {pin_out[9], pin_out[7], pin_out[6:3]});
            $display("receive test done");
        end
    endtask
    initial
    begin
        err_count = 0;
        checks = 0;
        presetn = 1'b1; // Lowered by rst so no block misses the edge
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pull = 11'h000;
        rxd = 4'h0;
        ev = 4'h0;
        rxv = 1'b0;
        rxe = 1'b0;
        irq = 1'b0;
        go = 1'b0;
        gap = 1'b0;
        first = 4'h0;
        rst(11'h555);
        led_t(2'h0, 2'h1);
        t_regs;
        t_irq;
        rx_t(32'h3A, 32'hFF);
        tx_t(4'h3, 1'b0, 4'hF);
        rst(11'h0AA);
        chk("isolate", 1, iso);
        rx_t(32'h32, 32'h1C);
        pull[1] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("isolated", 3'h4, {iso, pin_oe[6:5]});
        tx_t(4'hD, 1'b1, 4'h3);
        test_done;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        err_count = err_count + 1;
        test_done;
    end
endmodule
